// [tlmb_manager.sv]
`timescale 1ns/1ps
module tlmb_manager #(
  parameter int MEM_WORDS = 16
) (
  input wire logic clock_i,
  input wire logic srst_i,
  tlmb_if.manager tl,
  output logic a_first_o,
  output logic a_last_o,
  output logic a_done_o,
  output logic [tlmb_pkg::BEAT_W-1:0] a_count_o,
  output logic [tlmb_pkg::BEAT_W-1:0] a_beat_total_o,
  output logic [tlmb_pkg::BEAT_W-1:0] a_beat_total_minus_one_o
);
  import tlmb_pkg::*;
  localparam int IDX_W = $clog2(MEM_WORDS);
  typedef enum logic {ST_TAKE, ST_ANSWER} tlmb_mstate_t;

  tlmb_mstate_t state_q;
  logic [DATA_W-1:0] mem_q [MEM_WORDS];
  logic [BEAT_W-1:0] a_count_q;
  logic [BEAT_W-1:0] a_beats1;
  logic [BEAT_W-1:0] d_count_q;
  logic [BEAT_W-1:0] d_beats1_q;
  logic [IDX_W-1:0] a_idx;
  logic [IDX_W-1:0] base_idx_q;
  logic [IDX_W-1:0] next_idx;
  logic a_ready_q;
  logic d_valid_q;
  logic [2:0] d_opcode_q;
  logic [SIZE_W-1:0] d_size_q;
  logic [SRC_W-1:0] d_source_q;
  logic [DATA_W-1:0] d_data_q;
  logic a_fire;
  logic a_last;
  logic a_writes;
  logic a_txn_end;
  logic [DATA_W-1:0] old_word;
  logic [DATA_W-1:0] op_word;
  logic [DATA_W-1:0] merged;
  logic [DATA_W-1:0] byte_en;

  // the acknowledgement builder: data present selects the data form
  function automatic logic [2:0] ack_opcode(input logic data_supplied);
    return data_supplied ? OP_ACK_DATA : OP_ACK; // RL13
  endfunction

  assign a_fire = tl.a_valid && a_ready_q;
  assign a_beats1 = beat_total_minus_one(1'b0, tl.a_opcode, tl.a_size); // RL18
  assign a_last = a_count_q == a_beats1; // RL15
  assign a_first_o = a_count_q == RST_COUNT; // RL14
  assign a_last_o = a_last;
  assign a_done_o = a_fire && a_last; // RL16
  assign a_count_o = a_count_q; // RL17
  assign a_beat_total_o = a_beats1 + BEAT_W'(1); // RL18
  assign a_beat_total_minus_one_o = a_beats1;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      a_count_q <= RST_COUNT; // RL20
    else if (a_fire)
      a_count_q <= a_last ? RST_COUNT : a_count_q + BEAT_W'(1); // RL20
  end

  // addresses wrap inside the small store; higher bits are ignored
  assign a_idx = tl.a_address[LG_BEAT +: IDX_W] + a_count_q[IDX_W-1:0];
  assign next_idx = base_idx_q + d_count_q[IDX_W-1:0] + IDX_W'(1);
  assign old_word = mem_q[a_idx];
  assign a_writes = carries_payload(1'b0, tl.a_opcode); // RL19
  // a write burst answers only after its final beat
  assign a_txn_end = a_fire && (a_last || !a_writes);

  // the burst start is kept, since later beats step from it and not from the live address
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      base_idx_q <= '0;
    else if (a_txn_end)
      base_idx_q <= a_idx;
  end

  genvar gi;
  generate
    for (gi = 0; gi < MASK_W; gi++)
    begin : g_lane
      assign byte_en[8*gi +: 8] = {8{tl.a_mask[gi]}};
    end
  endgenerate

  // atomics act on the whole word; narrow ones rely on the lane mask to
  // keep the neighbours, so signed compares see the full 64-bit value
  always_comb
  begin
    op_word = tl.a_data;
    if (tl.a_opcode == OP_ARITH)
    begin
      case (tl.a_param)
        ATOM_MIN: op_word = ($signed(tl.a_data) < $signed(old_word)) ? tl.a_data : old_word;
        ATOM_MAX: op_word = ($signed(tl.a_data) > $signed(old_word)) ? tl.a_data : old_word;
        ATOM_MINU: op_word = (tl.a_data < old_word) ? tl.a_data : old_word;
        ATOM_MAXU: op_word = (tl.a_data > old_word) ? tl.a_data : old_word;
        ATOM_ADD: op_word = old_word + tl.a_data; // RL5
        default: op_word = old_word;
      endcase
    end
    else if (tl.a_opcode == OP_LOGIC)
    begin
      case (tl.a_param)
        LOGI_XOR: op_word = old_word ^ tl.a_data;
        LOGI_OR: op_word = old_word | tl.a_data;
        LOGI_AND: op_word = old_word & tl.a_data;
        LOGI_SWAP: op_word = tl.a_data; // RL7
        default: op_word = old_word;
      endcase
    end
    merged = (op_word & byte_en) | (old_word & ~byte_en);
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
        mem_q[i] <= '0;
    end
    else if (a_fire && a_writes)
      mem_q[a_idx] <= merged; // RL7
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_TAKE;
      a_ready_q <= 1'b1;
      d_valid_q <= 1'b0;
      d_opcode_q <= OP_ACK;
      d_size_q <= '0;
      d_source_q <= '0;
      d_data_q <= '0;
      d_count_q <= RST_COUNT;
      d_beats1_q <= RST_COUNT;
    end
    else
    begin
      case (state_q)
        ST_TAKE:
        begin
          if (a_txn_end)
          begin
            a_ready_q <= 1'b0;
            d_valid_q <= 1'b1;
            d_size_q <= tl.a_size;
            d_source_q <= tl.a_source;
            d_count_q <= RST_COUNT;
            d_beats1_q <= RST_COUNT;
            state_q <= ST_ANSWER;
            case (tl.a_opcode)
              OP_PUT_FULL, OP_PUT_PARTIAL:
              begin
                d_opcode_q <= ack_opcode(1'b0); // RL4
                d_data_q <= '0;
              end
              OP_ARITH, OP_LOGIC:
              begin
                d_opcode_q <= ack_opcode(1'b1); // RL6
                d_data_q <= old_word; // RL6
              end
              OP_GET:
              begin
                d_opcode_q <= ack_opcode(1'b1); // RL1
                d_data_q <= old_word;
                d_beats1_q <= beat_total_minus_one(1'b1, OP_ACK_DATA, tl.a_size); // RL1
              end
              default:
              begin
                // not a cache: a hint changes nothing here but is answered
                d_opcode_q <= OP_HINT_ACK; // RL9 RL10
                d_data_q <= '0;
              end
            endcase
          end
        end
        default:
        begin
          if (tl.d_ready)
          begin
            if (d_count_q != d_beats1_q)
            begin
              d_count_q <= d_count_q + BEAT_W'(1);
              d_data_q <= mem_q[next_idx];
            end
            else
            begin
              d_valid_q <= 1'b0;
              a_ready_q <= 1'b1;
              state_q <= ST_TAKE;
            end
          end
        end
      endcase
    end
  end

  assign tl.a_ready = a_ready_q;
  assign tl.d_valid = d_valid_q;
  assign tl.d_opcode = d_opcode_q;
  assign tl.d_size = d_size_q;
  assign tl.d_source = d_source_q;
  assign tl.d_data = d_data_q;
endmodule // tlmb_manager

// [tlmb_pkg.sv]
// Notes on behaviour
// RL1: get answered by multi-beat data ack
// RL2: masked write is partial, else full
// RL3: only data and mask vary per beat
// RL4: one plain ack per whole write
// RL5: five arithmetic ops, data is operand
// RL6: arithmetic returns prior value with data
// RL7: logical ops atomic, return prior value
// RL8: caches prefetch shared or exclusive
// RL9: non-cache manager only acknowledges hints
// RL10: every hint gets a hint ack
// RL11: size field is log2 of bytes
// RL12: each request carries a legality flag
// RL13: ack has data only when supplied
// RL14: first flag on transaction's first beat
// RL15: last flag on transaction's final beat
// RL16: done is handshake on final beat
// RL17: beat index counts from zero
// RL18: beat total and total minus one
// RL19: payload for puts, atomics, data acks
// RL20: index clears after final beat, reset
package tlmb_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int MASK_W = 8;
  localparam int SIZE_W = 4;
  localparam int SRC_W = 4;
  localparam int BEAT_W = 16;
  localparam int LG_BEAT = 3;
  localparam logic [SIZE_W-1:0] LG_BEAT_S = 4'h3;
  localparam logic [SIZE_W-1:0] LG_MAX_DEF = 4'h6;
  localparam logic [BEAT_W-1:0] RST_COUNT = 16'h0;
  localparam logic [2:0] OP_PUT_FULL = 3'h0;
  localparam logic [2:0] OP_PUT_PARTIAL = 3'h1;
  localparam logic [2:0] OP_ARITH = 3'h2;
  localparam logic [2:0] OP_LOGIC = 3'h3;
  localparam logic [2:0] OP_GET = 3'h4;
  localparam logic [2:0] OP_HINT = 3'h5;
  localparam logic [2:0] OP_ACK = 3'h0;
  localparam logic [2:0] OP_ACK_DATA = 3'h1;
  localparam logic [2:0] OP_HINT_ACK = 3'h2;
  localparam logic [2:0] ATOM_MIN = 3'h0;
  localparam logic [2:0] ATOM_MAX = 3'h1;
  localparam logic [2:0] ATOM_MINU = 3'h2;
  localparam logic [2:0] ATOM_MAXU = 3'h3;
  localparam logic [2:0] ATOM_ADD = 3'h4;
  localparam logic [2:0] LOGI_XOR = 3'h0;
  localparam logic [2:0] LOGI_OR = 3'h1;
  localparam logic [2:0] LOGI_AND = 3'h2;
  localparam logic [2:0] LOGI_SWAP = 3'h3;
  localparam logic [2:0] HINT_READ = 3'h0;
  localparam logic [2:0] HINT_WRITE = 3'h1;
  typedef enum logic [2:0] {KIND_GET, KIND_PUT, KIND_ARITH, KIND_LOGIC, KIND_HINT} tlmb_kind_t;

  function automatic logic carries_payload(input logic is_d, input logic [2:0] op);
    if (is_d)
      return op == OP_ACK_DATA; // RL19
    return op == OP_PUT_FULL || op == OP_PUT_PARTIAL || op == OP_ARITH || op == OP_LOGIC;
  endfunction

  function automatic logic [BEAT_W-1:0] beat_total_minus_one(input logic is_d,
      input logic [2:0] op, input logic [SIZE_W-1:0] size);
    logic [BEAT_W-1:0] n;
    n = '0;
    if (carries_payload(is_d, op) && size > LG_BEAT_S)
      n = (BEAT_W'(1) << (size - LG_BEAT_S)) - BEAT_W'(1); // RL18
    return n;
  endfunction

  function automatic logic [MASK_W-1:0] lane_mask(input logic [SIZE_W-1:0] size,
      input logic [2:0] off);
    logic [MASK_W-1:0] m;
    m = '1;
    if (size < LG_BEAT_S)
      m = ((MASK_W'(1) << (SIZE_W'(1) << size)) - MASK_W'(1)) << off;
    return m;
  endfunction
endpackage

// [tlmb_if.sv]
`timescale 1ns/1ps
interface tlmb_if;
  import tlmb_pkg::*;
  logic a_valid;
  logic a_ready;
  logic [2:0] a_opcode;
  logic [2:0] a_param;
  logic [SIZE_W-1:0] a_size;
  logic [SRC_W-1:0] a_source;
  logic [ADDR_W-1:0] a_address;
  logic [MASK_W-1:0] a_mask;
  logic [DATA_W-1:0] a_data;
  logic d_valid;
  logic d_ready;
  logic [2:0] d_opcode;
  logic [SIZE_W-1:0] d_size;
  logic [SRC_W-1:0] d_source;
  logic [DATA_W-1:0] d_data;
  modport client (
    output a_valid, a_opcode, a_param, a_size, a_source, a_address, a_mask, a_data,
    input a_ready,
    input d_valid, d_opcode, d_size, d_source, d_data,
    output d_ready
  );
  modport manager (
    input a_valid, a_opcode, a_param, a_size, a_source, a_address, a_mask, a_data,
    output a_ready,
    output d_valid, d_opcode, d_size, d_source, d_data,
    input d_ready
  );
endinterface

// [tlmb_client.sv]
`timescale 1ns/1ps
module tlmb_client #(
  parameter logic [3:0] LG_MAX = tlmb_pkg::LG_MAX_DEF
) (
  input wire logic clock_i,
  input wire logic srst_i,
  tlmb_if.client tl,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire tlmb_pkg::tlmb_kind_t req_kind_i,
  input wire logic [2:0] req_param_i,
  input wire logic [tlmb_pkg::SIZE_W-1:0] req_size_i,
  input wire logic [tlmb_pkg::SRC_W-1:0] req_source_i,
  input wire logic [tlmb_pkg::ADDR_W-1:0] req_address_i,
  input wire logic [tlmb_pkg::DATA_W-1:0] req_data_i,
  input wire logic [tlmb_pkg::MASK_W-1:0] req_mask_i,
  input wire logic req_mask_en_i,
  output logic req_legal_o,
  output logic resp_valid_o,
  input wire logic resp_ready_i,
  output logic [2:0] resp_opcode_o,
  output logic [tlmb_pkg::SRC_W-1:0] resp_source_o,
  output logic [tlmb_pkg::DATA_W-1:0] resp_data_o,
  output logic d_first_o,
  output logic d_last_o,
  output logic d_done_o,
  output logic [tlmb_pkg::BEAT_W-1:0] d_count_o,
  output logic [tlmb_pkg::BEAT_W-1:0] d_beat_total_o
);
  import tlmb_pkg::*;
  logic a_valid_q;
  logic req_ready_q;
  logic legal_q;
  logic [2:0] a_opcode_q;
  logic [2:0] a_param_q;
  logic [SIZE_W-1:0] a_size_q;
  logic [SRC_W-1:0] a_source_q;
  logic [ADDR_W-1:0] a_address_q;
  logic [MASK_W-1:0] a_mask_q;
  logic [DATA_W-1:0] a_data_q;
  logic [BEAT_W-1:0] tx_count_q;
  logic [BEAT_W-1:0] d_count_q;
  logic [BEAT_W-1:0] d_beats1;
  logic take;
  logic a_fire;
  logic d_fire;
  logic [2:0] new_op;
  logic [2:0] new_param;
  logic new_legal;
  logic align_ok;
  logic param_ok;

  assign take = req_ready_q && req_valid_i;
  assign a_fire = a_valid_q && tl.a_ready;
  assign align_ok = (req_address_i[15:0] & ((16'h1 << req_size_i) - 16'h1)) == 16'h0;

  always_comb
  begin
    new_op = OP_GET;
    new_param = 3'h0;
    param_ok = 1'b1;
    case (req_kind_i)
      KIND_PUT: new_op = req_mask_en_i ? OP_PUT_PARTIAL : OP_PUT_FULL; // RL2
      KIND_ARITH:
      begin
        new_op = OP_ARITH;
        new_param = req_param_i; // RL5
        param_ok = req_param_i <= ATOM_ADD;
      end
      KIND_LOGIC:
      begin
        new_op = OP_LOGIC;
        new_param = req_param_i; // RL7
        param_ok = req_param_i <= LOGI_SWAP;
      end
      KIND_HINT:
      begin
        new_op = OP_HINT;
        new_param = req_param_i; // RL8
        param_ok = req_param_i <= HINT_WRITE;
      end
      default: new_op = OP_GET; // RL1
    endcase
    // atomics are single beat, so they are limited to one word
    new_legal = align_ok && param_ok && req_size_i <= LG_MAX && // RL12
      !((new_op == OP_ARITH || new_op == OP_LOGIC) && req_size_i > LG_BEAT_S);
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      a_valid_q <= 1'b0;
      req_ready_q <= 1'b0;
      legal_q <= 1'b0;
      a_opcode_q <= OP_GET;
      a_param_q <= 3'h0;
      a_size_q <= '0;
      a_source_q <= '0;
      a_address_q <= '0;
      a_mask_q <= '0;
      a_data_q <= '0;
    end
    else
    begin
      req_ready_q <= !(take || (a_valid_q && !tl.a_ready));
      if (a_fire)
        a_valid_q <= 1'b0;
      if (take)
      begin
        a_valid_q <= 1'b1;
        a_data_q <= req_data_i;
        // header is held mid-transaction so a burst cannot drift
        if (tx_count_q == RST_COUNT)
        begin
          a_opcode_q <= new_op;
          a_param_q <= new_param;
          a_size_q <= req_size_i; // RL11
          a_source_q <= req_source_i;
          a_address_q <= req_address_i;
          legal_q <= new_legal;
          a_mask_q <= req_mask_en_i ? req_mask_i : lane_mask(req_size_i, req_address_i[2:0]);
        end
        else
          a_mask_q <= (a_opcode_q == OP_PUT_PARTIAL) ? req_mask_i : '1; // RL3
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      tx_count_q <= RST_COUNT;
    else if (a_fire)
      tx_count_q <= (tx_count_q == beat_total_minus_one(1'b0, a_opcode_q, a_size_q)) ?
        RST_COUNT : tx_count_q + BEAT_W'(1);
  end

  assign tl.a_valid = a_valid_q;
  assign tl.a_opcode = a_opcode_q;
  assign tl.a_param = a_param_q;
  assign tl.a_size = a_size_q;
  assign tl.a_source = a_source_q;
  assign tl.a_address = a_address_q;
  assign tl.a_mask = a_mask_q;
  assign tl.a_data = a_data_q;
  assign req_ready_o = req_ready_q;
  assign req_legal_o = legal_q;

  // response path is unbuffered so the user's ready is the channel's ready
  assign tl.d_ready = resp_ready_i;
  assign resp_valid_o = tl.d_valid;
  assign resp_opcode_o = tl.d_opcode;
  assign resp_source_o = tl.d_source;
  assign resp_data_o = tl.d_data;
  assign d_fire = tl.d_valid && resp_ready_i;
  assign d_beats1 = beat_total_minus_one(1'b1, tl.d_opcode, tl.d_size); // RL18
  assign d_first_o = d_count_q == RST_COUNT; // RL14
  assign d_last_o = d_count_q == d_beats1; // RL15
  assign d_done_o = d_fire && d_last_o; // RL16
  assign d_count_o = d_count_q; // RL17
  assign d_beat_total_o = d_beats1 + BEAT_W'(1);

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      d_count_q <= RST_COUNT; // RL20
    else if (d_fire)
      d_count_q <= d_last_o ? RST_COUNT : d_count_q + BEAT_W'(1); // RL20
  end
endmodule // tlmb_client

// [tlmb_props.sv]
`timescale 1ns/1ps
module tlmb_props
  import tlmb_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic a_valid,
  input wire logic a_ready,
  input wire logic [2:0] a_opcode,
  input wire logic [tlmb_pkg::SIZE_W-1:0] a_size,
  input wire logic [tlmb_pkg::SRC_W-1:0] a_source,
  input wire logic d_valid,
  input wire logic d_ready,
  input wire logic [2:0] d_opcode,
  input wire logic [tlmb_pkg::SIZE_W-1:0] d_size,
  input wire logic [tlmb_pkg::SRC_W-1:0] d_source,
  input wire logic [tlmb_pkg::DATA_W-1:0] d_data
);
  logic [BEAT_W-1:0] cnt_q;
  logic [BEAT_W-1:0] tot;
  logic a_fire;
  logic a_end;
  // own beat count, so a broken tracker in the manager cannot hide itself
  assign a_fire = a_valid && a_ready;
  assign tot = (a_opcode <= OP_LOGIC && a_size > LG_BEAT_S) ?
    (BEAT_W'(1) << (a_size - LG_BEAT_S)) - BEAT_W'(1) : RST_COUNT;
  assign a_end = a_fire && cnt_q == tot;
  always_ff @(posedge clock_i)
  begin
    if (srst_i || a_end)
      cnt_q <= '0;
    else if (a_fire)
      cnt_q <= cnt_q + 16'h1;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  sequence s_end(logic [2:0] op);
    a_end && a_opcode == op;
  endsequence
  sequence s_resp(logic [2:0] op);
    d_valid && d_opcode == op && d_size == $past(a_size) && d_source == $past(a_source);
  endsequence
  a_put_ack: assert property ((s_end(OP_PUT_FULL) or s_end(OP_PUT_PARTIAL)) |=> s_resp(OP_ACK))
    else $error("put not answered by one plain ack");
  a_get_data: assert property (s_end(OP_GET) |=> s_resp(OP_ACK_DATA))
    else $error("get not answered with data");
  a_atom_data: assert property ((s_end(OP_ARITH) or s_end(OP_LOGIC)) |=> s_resp(OP_ACK_DATA))
    else $error("atomic not answered with data");
  a_hint_ack: assert property (s_end(OP_HINT) |=> s_resp(OP_HINT_ACK))
    else $error("hint not answered by hint ack");
  a_single_ack: assert property (d_valid && d_ready && d_opcode != OP_ACK_DATA |=> !d_valid)
    else $error("more than one ack beat");
  a_ack_nodata: assert property (d_valid && d_opcode != OP_ACK_DATA |-> d_data == '0)
    else $error("dataless ack carries data");
  a_d_hold: assert property (d_valid && !d_ready |=> d_valid && $stable(d_opcode) && $stable(d_data))
    else $error("response changed while stalled");
  a_a_blocked: assert property (d_valid |-> !a_ready)
    else $error("request accepted during response");
  a_d_cause: assert property ($rose(d_valid) |-> $past(a_end))
    else $error("response without finished request");
endmodule // tlmb_props

// [tlmb_test.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tlmb_test;
  import tlmb_pkg::*;
  logic clock_i = 0, srst_i = 1, req_valid_i = 0, req_mask_en_i = 0, resp_ready_i = 0;
  tlmb_kind_t req_kind_i = KIND_GET;
  logic [2:0] req_param_i = 3'h0;
  logic [3:0] req_size_i = 4'h3, req_source_i = 4'h0;
  logic [31:0] req_address_i = 32'h0, rs = 32'hf202;
  logic [63:0] req_data_i = 64'h0;
  logic [7:0] req_mask_i = 8'h0;
  logic req_ready_o, req_legal_o, resp_valid_o, d_first_o, d_last_o, d_done_o;
  logic a_first_o, a_last_o, a_done_o;
  logic [2:0] resp_opcode_o;
  logic [3:0] resp_source_o;
  logic [63:0] resp_data_o;
  logic [15:0] d_count_o, d_beat_total_o, a_count_o, a_beat_total_o, a_tm1_o;
  logic [63:0] mem [16];
  int error_cnt = 0, checks_done = 0;
  tlmb_if tl_if ();
  tlmb_client i_tlmb_client (.clock_i, .srst_i, .tl(tl_if), .req_valid_i, .req_ready_o,
    .req_kind_i, .req_param_i, .req_size_i, .req_source_i, .req_address_i, .req_data_i,
    .req_mask_i, .req_mask_en_i, .req_legal_o, .resp_valid_o, .resp_ready_i, .resp_opcode_o,
    .resp_source_o, .resp_data_o, .d_first_o, .d_last_o, .d_done_o, .d_count_o,
    .d_beat_total_o);
  tlmb_manager i_tlmb_manager (.clock_i, .srst_i, .tl(tl_if), .a_first_o, .a_last_o,
    .a_done_o, .a_count_o, .a_beat_total_o, .a_beat_total_minus_one_o(a_tm1_o));
  tlmb_props chk (.clock_i, .srst_i, .a_valid(tl_if.a_valid), .a_ready(tl_if.a_ready),
    .a_opcode(tl_if.a_opcode), .a_size(tl_if.a_size), .a_source(tl_if.a_source),
    .d_valid(tl_if.d_valid), .d_ready(tl_if.d_ready), .d_opcode(tl_if.d_opcode),
    .d_size(tl_if.d_size), .d_source(tl_if.d_source), .d_data(tl_if.d_data));
  always #5 clock_i = ~clock_i;
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one whole transaction: model update, all request beats, all response beats
  task automatic txn(input tlmb_kind_t k, input logic [2:0] p, input logic [3:0] sz,
      input logic [31:0] ad, input logic [7:0] mk, input logic me, input logic lg);
    int na, nd, n, w;
    logic [63:0] d, o, r, bm;
    logic [63:0] q[$];
    logic [2:0] ea, eo;
    na = (k == KIND_PUT && sz > 3) ? 1 << (sz - 3) : 1;
    nd = (k == KIND_GET && sz > 3) ? 1 << (sz - 3) : 1;
    ea = k == KIND_PUT ? {2'b0, me} : k == KIND_GET ? OP_GET : k == KIND_ARITH ? OP_ARITH :
      k == KIND_LOGIC ? OP_LOGIC : OP_HINT;
    eo = k == KIND_PUT ? OP_ACK : k == KIND_HINT ? OP_HINT_ACK : OP_ACK_DATA;
    req_source_i = 4'(xs());
    for (int b = 0; b < na; b++)
    begin
      d = {xs(), xs()};
      w = (ad[6:3] + b) % 16;
      o = mem[w];
      bm = '1;
      for (int i = 0; i < 8; i++)
        if (me) bm[i*8 +: 8] = {8{mk[i]}};
      r = o;
      case (k)
        KIND_PUT: r = (o & ~bm) | (d & bm);
        KIND_ARITH: case (p)
          0: r = ($signed(o) < $signed(d)) ? o : d;
          1: r = ($signed(o) > $signed(d)) ? o : d;
          2: r = (o < d) ? o : d;
          3: r = (o > d) ? o : d;
          default: r = o + d;
        endcase
        KIND_LOGIC: case (p)
          0: r = o ^ d;
          1: r = o | d;
          2: r = o & d;
          default: r = d;
        endcase
        default: r = o;
      endcase
      mem[w] = r;
      if (k == KIND_ARITH || k == KIND_LOGIC) q.push_back(o);
      req_kind_i = k;
      req_param_i = p;
      req_size_i = sz;
      req_address_i = ad;
      req_data_i = d;
      req_mask_i = mk;
      req_mask_en_i = me;
      req_valid_i = 1;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 50)
      begin
        @(negedge clock_i);
        n++;
      end
      @(negedge clock_i);
      `CHK("a op", ea, tl_if.a_opcode)
      `CHK("a size", sz, tl_if.a_size)
      `CHK("a valid", 1'b1, tl_if.a_valid)
      `CHK("a addr", ad, tl_if.a_address)
      `CHK("a mask", me ? mk : 8'hff, tl_if.a_mask)
      `CHK("a param", p, tl_if.a_param)
      `CHK("a src", req_source_i, tl_if.a_source)
      `CHK("a count", 16'(b), a_count_o)
      `CHK("a first", b == 0, a_first_o)
      `CHK("a last", b == na - 1, a_last_o)
      `CHK("a done", b == na - 1, a_done_o)
      `CHK("a total", 16'(na), a_beat_total_o)
      `CHK("a total m1", 16'(na - 1), a_tm1_o)
      if (b == 0) `CHK("legal", lg, req_legal_o)
    end
    req_valid_i = 0;
    for (int b = 0; b < nd && k == KIND_GET; b++)
      q.push_back(mem[(ad[6:3] + b) % 16]);
    if (q.size() == 0) q.push_back(64'h0);
    for (int b = 0; b < nd; b++)
    begin
      n = 0;
      // random stalls keep the response standing for a while
      do
      begin
        @(negedge clock_i);
        resp_ready_i = ^xs() | (n > 6);
        #1;
        if (resp_valid_o === 1'b1 && !resp_ready_i) `CHK("d stall done", 1'b0, d_done_o)
        n++;
      end
      while (!(resp_valid_o === 1'b1 && resp_ready_i) && n < 50);
      `CHK("d valid", 1'b1, resp_valid_o)
      `CHK("d op", eo, resp_opcode_o)
      `CHK("d data", q[b], resp_data_o)
      `CHK("d src", req_source_i, resp_source_o)
      `CHK("d count", 16'(b), d_count_o)
      `CHK("d first", b == 0, d_first_o)
      `CHK("d last", b == nd - 1, d_last_o)
      `CHK("d done", b == nd - 1, d_done_o)
      `CHK("d total", 16'(nd), d_beat_total_o)
    end
    @(negedge clock_i);
    resp_ready_i = 0;
  endtask
  initial
  begin
    for (int i = 0; i < 16; i++) mem[i] = 64'h0;
    repeat (20) @(negedge clock_i);
    srst_i = 0;
    repeat (2) @(negedge clock_i);
    txn(KIND_PUT, 0, 3, 32'h18, 8'h0, 0, 1);
    txn(KIND_PUT, 0, 5, 32'h20, 8'h0, 0, 1);
    txn(KIND_PUT, 0, 3, 32'h10, 8'h5a, 1, 1);
    txn(KIND_PUT, 0, 4, 32'h40, 8'h3c, 1, 1);
    txn(KIND_GET, 0, 6, 32'h0, 8'h0, 0, 1);
    for (int p = 0; p < 5; p++) txn(KIND_ARITH, 3'(p), 3, 32'h18, 8'h0, 0, 1);
    for (int p = 0; p < 4; p++) txn(KIND_LOGIC, 3'(p), 3, 32'h18, 8'h0, 0, 1);
    txn(KIND_HINT, HINT_READ, 3, 32'h18, 8'h0, 0, 1);
    txn(KIND_HINT, HINT_WRITE, 3, 32'h18, 8'h0, 0, 1);
    txn(KIND_GET, 0, 3, 32'h18, 8'h0, 0, 1);
    txn(KIND_GET, 0, 3, 32'h0c, 8'h0, 0, 0);
    txn(KIND_GET, 0, 7, 32'h0, 8'h0, 0, 0);
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    give_verdict;
  end
endmodule // tlmb_test
